// ===== hw/pom_pkg.sv
// Constants, field layouts and types of the PLC output register block
package pom_pkg;
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 16;
  // Register offsets
  localparam logic [7:0]  ADR_L_TGT   = 8'h08;
  localparam logic [7:0]  ADR_L_CMD   = 8'h09;
  localparam logic [7:0]  ADR_R_TGT   = 8'h0d;
  localparam logic [7:0]  ADR_R_CMD   = 8'h0e;
  localparam logic [7:0]  ADR_MASK    = 8'h22;
  localparam logic [7:0]  ADR_US      = 8'h74;
  localparam logic [7:0]  ADR_DS      = 8'hc4;
  localparam logic [7:0]  ADR_TRK1    = 8'hc9;
  localparam logic [7:0]  ADR_TRK2    = 8'hca;
  // Reset value of every register
  localparam logic [15:0] REG_RST     = 16'h0000;
  // Neighbour status codes
  localparam logic [15:0] DS_WAKE     = 16'h0004;
  localparam logic [15:0] DS_EXIT     = 16'h0001;
  localparam logic [15:0] US_HOLD     = 16'h0005;
  localparam logic [15:0] US_RELEASE  = 16'h0001;
  // Mask bit positions
  localparam int          MSK_L_AUX   = 0;
  localparam int          MSK_R_AUX   = 2;
  localparam int          MSK_L_SNS   = 4;
  localparam int          MSK_R_SNS   = 6;
  localparam logic [15:0] MASK_VALID  = 16'h0055;
  // Servo command bits
  localparam int          CMD_ZERO    = 0;
  localparam int          CMD_RUN     = 1;
  // Servo target limits
  localparam logic [15:0] TGT_MIN     = 16'h8001;
  localparam logic [15:0] TGT_MAX     = 16'h7fff;
  localparam logic [15:0] TGT_ILLEGAL = 16'h8000;

  typedef enum logic [2:0] {
    SV_IDLE = 3'b001,
    SV_MOVE = 3'b010,
    SV_DONE = 3'b100
  } pom_sv_state_t;

  typedef struct packed {
    logic zero_ack;
    logic ready;
  } pom_sstat_t;

  typedef struct packed {
    logic run;
    logic ccw;
  } pom_drive_t;
endpackage

// ===== hw/pom_plc_output_block.sv
// Output registers: neighbour status, input mask, servo commands
//
// What this block does
// - Downstream status written 4 wakes downstream neighbour's first zone.
// - Downstream status written 1 reports carton exit, sends tracking.
// - Upstream status written 5 tells upstream discharge zone to hold.
// - Upstream status written 1 tells upstream discharge zone to release.
// - Tracking words are forwarded only in PLC input/output operation.
// - Mask bits 0,2,4,6: left aux, right aux, left and right sensor.
// - Input bit is pin state xor mask bit; LED lights on a one.
// - Entering PLC input/output operation clears the mask.
// - In zone mode auto-configuration loads the mask for blocked LED.
// - Command bit 0 set zeroes that motor's servo position while its servo is idle.
// - Command bit 1 moves the motor to its target value.
// - Target is a signed position, taken at the next run command.
// - Target is limited to -32767 through +32767.
// - Target unit is millimetres for roller, pulses for gear motors.
// - Servo move uses the motor's speed, accel and decel registers.
// - In servo use, ordinary run, stop and direction are ignored.
// - Ready sets when a move ends, clears after run is cleared.
// - Zero command is acknowledged by servo status bit 1.
// - Target at or above the position turns counter-clockwise, below it clockwise.
`timescale 1ns/1ps
`default_nettype none
module pom_plc_output_block
  import pom_pkg::*;
(
  input  wire logic              I_CLOCK,
  input  wire logic              I_SRST,
  input  wire logic              I_WR_EN,
  input  wire logic              I_RD_EN,
  input  wire logic [7:0]        I_ADDR,
  input  wire logic [15:0]       I_WR_DATA,
  output logic      [15:0]       O_RD_DATA,
  output logic                   O_RD_VALID,
  input  wire logic              I_PLC_IO_MODE,
  input  wire logic              I_AUTOCFG_LOAD,
  input  wire logic [15:0]       I_AUTOCFG_MASK,
  input  wire logic [3:0]        I_SENSOR_PINS,
  output logic      [3:0]        O_SENSOR_IN,
  output logic      [3:0]        O_SENSOR_LED,
  input  wire logic [1:0][15:0]  I_SPEED,
  input  wire logic [1:0][15:0]  I_ACCEL,
  input  wire logic [1:0][15:0]  I_DECEL,
  input  wire logic [1:0]        I_SERVO_EN,
  input  wire logic [1:0]        I_RUN_CMD,
  input  wire logic [1:0]        I_DIR_REV,
  input  wire logic [1:0]        I_CFG_CCW,
  output logic      [1:0]        O_MOTOR_RUN,
  output logic      [1:0]        O_MOTOR_CCW,
  output logic      [1:0]        O_MOTOR_STEP,
  output logic      [1:0][15:0]  O_SERVO_POS,
  output pom_sstat_t [1:0]       O_SERVO_STATUS,
  output logic                   O_DS_WAKE,
  output logic                   O_DS_EXIT,
  output logic      [31:0]       O_DS_TRACK,
  output logic                   O_US_HOLD,
  output logic                   O_US_RELEASE
);
  logic [1:0][15:0] cmd_q;
  logic [1:0][15:0] tgt_q;
  logic [15:0]      mask_q;
  logic [15:0]      us_q;
  logic [15:0]      ds_q;
  logic [15:0]      trk1_q;
  logic [15:0]      trk2_q;
  logic             plc_q;
  logic [3:0]       pins_s;
  logic [1:0][15:0] pos_w;
  pom_sstat_t [1:0] stat_w;
  pom_drive_t [1:0] drv_w;
  logic [1:0]       step_w;
  logic [15:0]      rd_d;

  // Write strobes
  wire wr_mask = I_WR_EN && I_ADDR == ADR_MASK;
  wire wr_us   = I_WR_EN && I_ADDR == ADR_US;
  wire wr_ds   = I_WR_EN && I_ADDR == ADR_DS;
  wire wr_trk1 = I_WR_EN && I_ADDR == ADR_TRK1;
  wire wr_trk2 = I_WR_EN && I_ADDR == ADR_TRK2;
  wire [1:0] wr_cmd = {I_WR_EN && I_ADDR == ADR_R_CMD,
                       I_WR_EN && I_ADDR == ADR_L_CMD};
  wire [1:0] wr_tgt = {I_WR_EN && I_ADDR == ADR_R_TGT,
                       I_WR_EN && I_ADDR == ADR_L_TGT};

  wire enter_plc = I_PLC_IO_MODE && !plc_q;
  wire zone_mode = !I_PLC_IO_MODE;

  // clamp the one value outside the range
  wire [15:0] tgt_wr = (I_WR_DATA == TGT_ILLEGAL) ? TGT_MIN : I_WR_DATA;

  wire [3:0] mask_bits = {mask_q[MSK_R_SNS], mask_q[MSK_L_SNS],
                          mask_q[MSK_R_AUX], mask_q[MSK_L_AUX]};
  wire [3:0] cond_in = pins_s ^ mask_bits;

  always_comb begin
    case (I_ADDR)
      ADR_L_TGT: rd_d = tgt_q[0];
      ADR_L_CMD: rd_d = cmd_q[0];
      ADR_R_TGT: rd_d = tgt_q[1];
      ADR_R_CMD: rd_d = cmd_q[1];
      ADR_MASK:  rd_d = mask_q;
      ADR_US:    rd_d = us_q;
      ADR_DS:    rd_d = ds_q;
      ADR_TRK1:  rd_d = trk1_q;
      ADR_TRK2:  rd_d = trk2_q;
      default:   rd_d = 16'h0000;
    endcase
  end

  pom_sync #(
    .W (4)
  ) u_pin_sync (
    .i_clk   (I_CLOCK),
    .i_srst  (I_SRST),
    .i_async (I_SENSOR_PINS),
    .o_sync  (pins_s)
  );

  for (genvar m = 0; m < 2; m++) begin : g_axis
    pom_servo_axis u_axis (
      .i_clk    (I_CLOCK),
      .i_srst   (I_SRST),
      .i_cmd    (cmd_q[m]),
      .i_target (tgt_q[m]),
      .i_speed  (I_SPEED[m]),
      .i_accel  (I_ACCEL[m]),
      .i_decel  (I_DECEL[m]),
      .o_pos    (pos_w[m]),
      .o_stat   (stat_w[m]),
      .o_drive  (drv_w[m]),
      .o_step   (step_w[m])
    );

    always_ff @(posedge I_CLOCK) begin
      if (I_SRST) begin
        cmd_q[m]          <= REG_RST;
        tgt_q[m]          <= REG_RST;
        O_MOTOR_RUN[m]    <= 1'b0;
        O_MOTOR_CCW[m]    <= 1'b0;
        O_MOTOR_STEP[m]   <= 1'b0;
        O_SERVO_POS[m]    <= '0;
        O_SERVO_STATUS[m] <= '0;
      end else begin
        if (wr_cmd[m]) cmd_q[m] <= I_WR_DATA;
        if (wr_tgt[m]) tgt_q[m] <= tgt_wr;
        // servo takes over run and direction
        O_MOTOR_RUN[m]    <= I_SERVO_EN[m] ? drv_w[m].run : I_RUN_CMD[m];
        O_MOTOR_CCW[m]    <= I_SERVO_EN[m] ? drv_w[m].ccw
                                           : I_CFG_CCW[m] ^ I_DIR_REV[m];
        O_MOTOR_STEP[m]   <= I_SERVO_EN[m] && step_w[m];
        O_SERVO_POS[m]    <= pos_w[m];
        O_SERVO_STATUS[m] <= stat_w[m];
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      mask_q <= REG_RST;
      plc_q  <= 1'b0;
    end else begin
      plc_q <= I_PLC_IO_MODE;
      // clear on entry to PLC operation
      if (enter_plc) begin
        mask_q <= REG_RST;
      end else if (wr_mask) begin
        mask_q <= I_WR_DATA & MASK_VALID;
      end else if (I_AUTOCFG_LOAD && zone_mode) begin
        mask_q <= I_AUTOCFG_MASK & MASK_VALID;
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      us_q   <= REG_RST;
      ds_q   <= REG_RST;
      trk1_q <= REG_RST;
      trk2_q <= REG_RST;
    end else begin
      if (wr_us) us_q <= I_WR_DATA;
      if (wr_ds) ds_q <= I_WR_DATA;
      if (wr_trk1) trk1_q <= I_WR_DATA;
      if (wr_trk2) trk2_q <= I_WR_DATA;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      O_DS_WAKE    <= 1'b0;
      O_DS_EXIT    <= 1'b0;
      O_DS_TRACK   <= '0;
      O_US_HOLD    <= 1'b0;
      O_US_RELEASE <= 1'b0;
    end else begin
      O_DS_WAKE    <= wr_ds && I_WR_DATA == DS_WAKE;
      O_DS_EXIT    <= wr_ds && I_WR_DATA == DS_EXIT;
      O_US_HOLD    <= wr_us && I_WR_DATA == US_HOLD;
      O_US_RELEASE <= wr_us && I_WR_DATA == US_RELEASE;
      if (!I_PLC_IO_MODE) begin
        O_DS_TRACK <= '0;
      end else if (wr_ds && I_WR_DATA == DS_EXIT) begin
        O_DS_TRACK <= {trk1_q, trk2_q};
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      O_RD_DATA    <= '0;
      O_RD_VALID   <= 1'b0;
      O_SENSOR_IN  <= '0;
      O_SENSOR_LED <= '0;
    end else begin
      O_RD_VALID   <= I_RD_EN;
      if (I_RD_EN) O_RD_DATA <= rd_d;
      O_SENSOR_IN  <= cond_in;
      O_SENSOR_LED <= cond_in;
    end
  end

  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_SRST);

  sequence s_ds_write(logic [15:0] v);
    I_WR_EN && I_ADDR == ADR_DS && I_WR_DATA == v;
  endsequence
  sequence s_us_write(logic [15:0] v);
    I_WR_EN && I_ADDR == ADR_US && I_WR_DATA == v;
  endsequence

  a_ds_wake: assert property (
    s_ds_write(DS_WAKE) |=> O_DS_WAKE && !O_DS_EXIT ##1
      (!O_DS_WAKE || $past(wr_ds && I_WR_DATA == DS_WAKE)))
    else $error("wake not sent downstream");
  a_ds_other: assert property (
    wr_ds && I_WR_DATA != DS_WAKE && I_WR_DATA != DS_EXIT
      |=> !O_DS_WAKE && !O_DS_EXIT)
    else $error("stored status value sent a pulse");
  a_ds_exit: assert property (
    s_ds_write(DS_EXIT) and I_PLC_IO_MODE
      |=> O_DS_EXIT && O_DS_TRACK == {$past(trk1_q), $past(trk2_q)})
    else $error("carton exit or tracking wrong");
  a_us_hold: assert property (
    s_us_write(US_HOLD) |=> O_US_HOLD && !O_US_RELEASE)
    else $error("hold not sent upstream");
  a_us_release: assert property (
    s_us_write(US_RELEASE) |=> O_US_RELEASE && !O_US_HOLD)
    else $error("release not sent upstream");
  a_track_gate: assert property (
    !I_PLC_IO_MODE |=> O_DS_TRACK == 32'h0000_0000)
    else $error("tracking forwarded outside PLC operation");
  a_track_hold: assert property (
    I_PLC_IO_MODE && !(wr_ds && I_WR_DATA == DS_EXIT) |=> $stable(O_DS_TRACK))
    else $error("tracking changed without carton exit");
  a_mask_write: assert property (
    wr_mask && !enter_plc |=> mask_q == ($past(I_WR_DATA) & MASK_VALID))
    else $error("mask write did not keep valid bits");
  a_led_cond: assert property (
    ##1 O_SENSOR_IN == $past(pins_s ^ mask_bits)
      && O_SENSOR_LED == O_SENSOR_IN)
    else $error("input conditioning wrong");
  a_mask_entry: assert property (
    $rose(I_PLC_IO_MODE) |=> mask_q == 16'h0000)
    else $error("mask not cleared on PLC entry");
  a_mask_load: assert property (
    I_AUTOCFG_LOAD && zone_mode && !wr_mask && !enter_plc
      |=> mask_q == ($past(I_AUTOCFG_MASK) & MASK_VALID))
    else $error("auto-configuration mask not loaded");
  a_tgt_clamp: assert property (
    wr_tgt[0] && I_WR_DATA == TGT_ILLEGAL |=> tgt_q[0] == TGT_MIN)
    else $error("target not limited");
  a_tgt_clamp_r: assert property (
    wr_tgt[1] && I_WR_DATA == TGT_ILLEGAL |=> tgt_q[1] == TGT_MIN)
    else $error("right target not limited");
  a_tgt_store: assert property (
    wr_tgt[0] && I_WR_DATA != TGT_ILLEGAL |=> tgt_q[0] == $past(I_WR_DATA))
    else $error("target not stored");
  a_cmd_store: assert property (
    wr_cmd[1] |=> cmd_q[1] == $past(I_WR_DATA))
    else $error("servo command not stored");
  a_servo_dir: assert property (
    I_SERVO_EN[1] |=> O_MOTOR_CCW[1] == $past(drv_w[1].ccw))
    else $error("servo direction not applied");
  a_zero_stat: assert property (
    stat_w[1].zero_ack |=> O_SERVO_STATUS[1].zero_ack)
    else $error("zero acknowledge not shown");
  a_ord_run: assert property (
    !I_SERVO_EN[1] |=> O_MOTOR_RUN[1] == $past(I_RUN_CMD[1]))
    else $error("ordinary run not followed");
  a_servo_own: assert property (
    I_SERVO_EN[0] && !drv_w[0].run |=> !O_MOTOR_RUN[0])
    else $error("ordinary run leaked into servo use");
endmodule
`default_nettype wire

// ===== hw/pom_servo_axis.sv
// Servo position loop of one motor
`timescale 1ns/1ps
`default_nettype none
module pom_servo_axis
  import pom_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_srst,
  input  wire logic        [15:0] i_cmd,
  input  wire logic signed [15:0] i_target,
  input  wire logic        [15:0] i_speed,
  input  wire logic        [15:0] i_accel,
  input  wire logic        [15:0] i_decel,
  output logic signed      [15:0] o_pos,
  output pom_sstat_t              o_stat,
  output pom_drive_t              o_drive,
  output logic                    o_step
);
  pom_sv_state_t      state_q;
  logic signed [15:0] tgt_q;
  logic signed [15:0] start_q;
  logic        [15:0] acc_q;

  wire               run_w  = i_cmd[CMD_RUN];
  wire               zero_w = i_cmd[CMD_ZERO];
  wire signed [16:0] diff_w = 17'(tgt_q) - 17'(o_pos);
  wire signed [16:0] trav_w = 17'(o_pos) - 17'(start_q);
  wire        [16:0] rem_w  = diff_w[16] ? 17'(-diff_w) : 17'(diff_w);
  wire        [16:0] done_w = trav_w[16] ? 17'(-trav_w) : 17'(trav_w);
  // Half speed inside the accel and decel distances
  wire        ramp_w = (done_w < {1'b0, i_accel}) ||
                       (rem_w <= {1'b0, i_decel});
  wire [15:0] vraw_w = ramp_w ? {1'b0, i_speed[15:1]} : i_speed;
  wire [15:0] vel_w  = (vraw_w == 16'h0000) ? 16'h0001 : vraw_w;
  wire [16:0] sum_w  = {1'b0, acc_q} + {1'b0, vel_w};
  wire        up_w   = !diff_w[16];
  wire signed [15:0] nxt_w = up_w ? o_pos + 16'sh0001
                                  : o_pos - 16'sh0001;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_q  <= SV_IDLE;
      tgt_q    <= '0;
      start_q  <= '0;
      acc_q    <= '0;
      o_pos    <= '0;
      o_stat   <= '0;
      o_drive  <= '0;
      o_step   <= 1'b0;
    end else begin
      o_step <= 1'b0;
      // zero ack follows the command bit
      if (!zero_w) o_stat.zero_ack <= 1'b0;
      case (state_q)
        SV_IDLE: begin
          acc_q <= '0;
          if (zero_w) begin
            o_pos           <= '0;
            o_stat.zero_ack <= 1'b1;
          end else if (run_w) begin
            tgt_q   <= i_target;
            start_q <= o_pos;
            state_q <= (i_target == o_pos) ? SV_DONE : SV_MOVE;
          end
        end
        SV_MOVE: begin
          acc_q <= sum_w[15:0];
          // step rate from speed and ramps
          if (!run_w) begin
            state_q <= SV_IDLE;
          end else if (sum_w[16]) begin
            // one count per millimetre or pulse
            o_pos  <= nxt_w;
            o_step <= 1'b1;
            if (nxt_w == tgt_q) state_q <= SV_DONE;
          end
        end
        SV_DONE: begin
          o_stat.ready <= run_w;
          if (!run_w) state_q <= SV_IDLE;
        end
        default: state_q <= SV_IDLE;
      endcase
      o_drive.run <= (state_q == SV_MOVE) && run_w;
      o_drive.ccw <= up_w;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);

  a_zero_pos_ack: assert property (
    state_q == SV_IDLE && zero_w |=> o_pos == 0 && o_stat.zero_ack)
    else $error("zero command did not clear position");
  a_ready_drop: assert property (
    o_stat.ready && !run_w |=> !o_stat.ready && state_q == SV_IDLE)
    else $error("ready not cleared after run dropped");
  a_step_dir: assert property (
    o_step && tgt_q > $past(o_pos) |-> o_pos == $past(o_pos) + 16'sh0001)
    else $error("step went the wrong way");
endmodule
`default_nettype wire

// ===== hw/pom_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pom_sync #(
  parameter int W = 4
) (
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q;

  if (W < 1) begin : g_chk
    $error("pom_sync: W must be at least 1");
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/pom_plc_model.sv
// PLC side model: register writes and reads over the strobe bus
`timescale 1ns/1ps
`default_nettype none
module pom_plc_model (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_rd_data,
  input  wire logic        i_rd_valid,
  output logic             o_wr_en,
  output logic             o_rd_en,
  output logic      [7:0]  o_addr,
  output logic      [15:0] o_wr_data
);
  initial begin
    o_wr_en   = 1'b0;
    o_rd_en   = 1'b0;
    o_addr    = 8'h00;
    o_wr_data = 16'h0000;
  end
  // Released bus shows inverted values, never the old ones
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_wr_en   <= 1'b1;
    o_addr    <= a;
    o_wr_data <= d;
    @(posedge i_clk);
    o_wr_en   <= 1'b0;
    o_addr    <= ~a;
    o_wr_data <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] q,
                    output logic v);
    @(posedge i_clk);
    o_rd_en <= 1'b1;
    o_addr  <= a;
    @(posedge i_clk);
    o_rd_en <= 1'b0;
    o_addr  <= ~a;
    #1;
    v = i_rd_valid;
    q = i_rd_data;
  endtask
endmodule
`default_nettype wire

// ===== testbench/test_pom_plc_output_block.sv
// Self-checking bench of the PLC output register block
`timescale 1ns/1ps
`default_nettype none
module test_pom_plc_output_block;
  import pom_pkg::*;
  localparam logic [7:0] REGS [9] = '{ADR_L_TGT, ADR_L_CMD, ADR_R_TGT,
    ADR_R_CMD, ADR_MASK, ADR_US, ADR_DS, ADR_TRK1, ADR_TRK2};
  localparam logic [7:0]  ST_A [5] = '{ADR_DS, ADR_DS, ADR_US, ADR_US,
                                       ADR_DS};
  localparam logic [15:0] ST_V [5] = '{DS_WAKE, DS_EXIT, US_HOLD,
                                       US_RELEASE, 16'h0002};
  localparam logic [3:0]  ST_E [5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0};
  logic             clk, srst, mode, ld, wr_en, rd_en, rd_v, dir;
  logic [7:0]       addr, a_t, a_c;
  logic [15:0]      ld_mask, wr_d, rd_d, rnd, t, t1, t2;
  logic [3:0]       pins, s_in, s_led;
  logic [1:0][15:0] speed, accel, decel, pos;
  logic [1:0]       srv_en, run_cmd, rev, cfg, m_run, m_ccw, m_step;
  pom_sstat_t [1:0] stat;
  logic             wake, exit_p, hold, rel;
  logic [31:0]      track;
  int               err_count, check_count, n, m, mag, steps;

  pom_plc_output_block i_pom_plc_output_block (
    .I_CLOCK(clk), .I_SRST(srst), .I_WR_EN(wr_en), .I_RD_EN(rd_en),
    .I_ADDR(addr), .I_WR_DATA(wr_d), .O_RD_DATA(rd_d), .O_RD_VALID(rd_v),
    .I_PLC_IO_MODE(mode), .I_AUTOCFG_LOAD(ld), .I_AUTOCFG_MASK(ld_mask),
    .I_SENSOR_PINS(pins), .O_SENSOR_IN(s_in), .O_SENSOR_LED(s_led),
    .I_SPEED(speed), .I_ACCEL(accel), .I_DECEL(decel),
    .I_SERVO_EN(srv_en), .I_RUN_CMD(run_cmd), .I_DIR_REV(rev),
    .I_CFG_CCW(cfg), .O_MOTOR_RUN(m_run), .O_MOTOR_CCW(m_ccw),
    .O_MOTOR_STEP(m_step), .O_SERVO_POS(pos), .O_SERVO_STATUS(stat),
    .O_DS_WAKE(wake), .O_DS_EXIT(exit_p), .O_DS_TRACK(track),
    .O_US_HOLD(hold), .O_US_RELEASE(rel));

  pom_plc_model i_pom_plc_model (
    .i_clk(clk), .i_rd_data(rd_d), .i_rd_valid(rd_v), .o_wr_en(wr_en),
    .o_rd_en(rd_en), .o_addr(addr), .o_wr_data(wr_d));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [3:0] exp_in(input logic [3:0] p,
                                        input logic [15:0] k);
    return p ^ {k[6], k[4], k[2], k[0]};
  endfunction

  task automatic close_out();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tmo(input logic ok);
    if (ok !== 1'b1) begin
      err_count++;
      $display("[ERR] wait exp 1 seen %b", ok);
      close_out();
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [15:0] d);
    i_pom_plc_model.wr(a, d);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [15:0] e);
    logic [15:0] q;
    logic        v;
    i_pom_plc_model.rd(a, q, v);
    chk({nm, " valid"}, {31'h0, v}, 32'h1);
    chk(nm, {16'h0, q}, {16'h0, e});
  endtask
  // inputs trusted only after the mask has landed
  task automatic sns(input logic [15:0] k);
    repeat (4) @(posedge clk);
    #1;
    chk("sensor in", {28'h0, s_in}, {28'h0, exp_in(pins, k)});
    chk("sensor led", {28'h0, s_led}, {28'h0, exp_in(pins, k)});
  endtask

  initial begin
    err_count = 0;
    check_count = 0;
    rnd = 16'h0035;
    {srst, mode, ld, ld_mask, pins} = {1'b1, 1'b0, 1'b0, 16'h0, 4'h5};
    speed = {16'hffff, 16'hffff};
    accel = {16'h0003, 16'h0002};
    decel = {16'h0002, 16'h0003};
    {srv_en, run_cmd, rev, cfg} = {2'b00, 2'b01, 2'b11, 2'b01};
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    foreach (REGS[i]) rdc("reset", REGS[i], REG_RST);
    rdc("unmapped", 8'h55, 16'h0000);
    #1;
    chk("plain run", {30'h0, m_run}, 32'h1);
    chk("plain dir", {30'h0, m_ccw}, 32'h2);
    rnd = lfsr(rnd);
    @(posedge clk);
    ld <= 1'b1;
    ld_mask <= rnd;
    @(posedge clk);
    ld <= 1'b0;
    rdc("autocfg", ADR_MASK, rnd & MASK_VALID);
    sns(rnd & MASK_VALID);
    @(posedge clk);
    mode <= 1'b1;
    rdc("mask clear", ADR_MASK, 16'h0000);
    for (n = 0; n < 6; n++) begin
      rnd = lfsr(rnd);
      w(ADR_MASK, rnd);
      rdc("mask", ADR_MASK, rnd & MASK_VALID);
      @(posedge clk);
      pins <= rnd[11:8];
      sns(rnd & MASK_VALID);
    end
    t1 = lfsr(rnd);
    t2 = lfsr(t1);
    w(ADR_TRK1, t1);
    w(ADR_TRK2, t2);
    for (n = 0; n < 5; n++) begin
      w(ST_A[n], ST_V[n]);
      #1;
      chk("pulse", {wake, exit_p, hold, rel}, ST_E[n]);
      @(posedge clk);
      #1;
      chk("pulse end", {wake, exit_p, hold, rel}, 4'h0);
    end
    chk("track", track, {t1, t2});
    rdc("ds store", ADR_DS, 16'h0002);
    @(posedge clk);
    srv_en <= 2'b11;
    run_cmd <= 2'b11;
    @(posedge clk);
    mode <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("track off", track, 32'h0);
    chk("servo idle", {30'h0, m_run}, 32'h0);
    for (m = 0; m < 2; m++) begin
      rnd = lfsr(rnd);
      mag = int'(rnd[5:0]) + 4;
      t = m ? -16'(mag) : 16'(mag);
      a_t = m ? ADR_R_TGT : ADR_L_TGT;
      a_c = m ? ADR_R_CMD : ADR_L_CMD;
      w(a_t, 16'h8000);
      rdc("tgt limit", a_t, TGT_MIN);
      w(a_t, t);
      w(a_c, 16'h0002);
      steps = 0;
      dir = 1'bx;
      for (n = 0; n < 3000 && stat[m].ready !== 1'b1; n++) begin
        @(posedge clk);
        #1;
        steps += int'(m_step[m]);
        if (m_run[m] === 1'b1) dir = m_ccw[m];
      end
      tmo(stat[m].ready);
      chk("pos", {16'h0, pos[m]}, {16'h0, t});
      chk("steps", steps, mag);
      chk("dir", {31'h0, dir}, m ? 32'h0 : 32'h1);
      chk("stopped", {31'h0, m_run[m]}, 32'h0);
      w(a_c, 16'h0000);
      for (n = 0; n < 20 && stat[m].ready !== 1'b0; n++) begin
        @(posedge clk);
        #1;
      end
      tmo(!stat[m].ready);
      w(a_c, 16'h0001);
      for (n = 0; n < 20 && stat[m].zero_ack !== 1'b1; n++) begin
        @(posedge clk);
        #1;
      end
      tmo(stat[m].zero_ack);
      chk("zero", {16'h0, pos[m]}, 32'h0);
      w(a_c, 16'h0000);
      for (n = 0; n < 20 && stat[m].zero_ack !== 1'b0; n++) begin
        @(posedge clk);
        #1;
      end
      tmo(!stat[m].zero_ack);
    end
    close_out();
  end
endmodule
`default_nettype wire
